/* pstr_flash_model.sv */
/* Flash array model: a 24-bit word derived from each address.
   Assumes the block samples read data while its strobe is high. */
`timescale 1ns/1ps
module pstr_flash_model (
  input wire logic rd_in,
  input wire logic [23:0] addr_in,
  output logic [23:0] rdata_out
);
  logic [23:0] word;
  // Lower word on the even address, upper byte beside it
  assign word = {addr_in[7:0] ^ 8'h5A, addr_in[15:0] ^ 16'hC3A5};
  // Outside a strobe the bus shows the inverse, so stale data cannot pass
  assign rdata_out = rd_in ? word : ~word;
endmodule

/* pstr_lane.sv */
`timescale 1ns/1ps
/*
  Read lane steering for one table read: picks the bytes of the 24-bit
  program word and places them in the 16-bit data result.
  Purely combinational; the caller registers the result.
*/
module pstr_lane
  import pstr_pkg::*;
(
  input wire logic [23:0] pword_in,
  input wire logic high_in,
  input wire logic byte_mode_in,
  input wire logic byte_sel_in,
  output logic [15:0] data_out
);
  // Byte and word cases of both read kinds
  always_comb begin
    data_out = 16'h0000;
    if (!high_in) begin
      if (!byte_mode_in) begin
        data_out = pword_in[15:0];
      end else begin
        data_out = {8'h00, byte_sel_in ? pword_in[15:8] : pword_in[7:0]};
      end
    end else begin
      if (!byte_mode_in) begin
        data_out = {PSTR_PHANTOM, pword_in[23:16]};
      end else begin
        // Phantom byte has no storage, so it always reads zero
        data_out = {8'h00, byte_sel_in ? PSTR_PHANTOM : pword_in[23:16]};
      end
    end
  end
endmodule

/* pstr_pkg.sv */
/*
  Package for the program space table access block: widths, field
  positions, reset values and the operation encoding.
  Assumes a 24-bit program flash array and a 16-bit core data path.
*/
package pstr_pkg;
  localparam int PSTR_PWORD_W = 24;
  localparam int PSTR_DWORD_W = 16;
  localparam int PSTR_EA_W = 16;
  localparam int PSTR_PAGE_W = 8;
  localparam int PSTR_PAGE_CFG_BIT = 7;
  localparam int PSTR_PADDR_W = PSTR_PAGE_W + PSTR_EA_W;
  localparam int PSTR_ADDR_STEP = 2;
  localparam logic [7:0] PSTR_PAGE_RST = 8'h00;
  localparam logic [7:0] PSTR_PHANTOM = 8'h00;
  // Operation issued by the core with each table instruction
  typedef enum logic [1:0] {
    PSTR_OP_RD_LOW,
    PSTR_OP_RD_HIGH,
    PSTR_OP_WT_LOW,
    PSTR_OP_WT_HIGH
  } pstr_op_e;
endpackage

/* pstr_table_access.sv */
`timescale 1ns/1ps
/*
  Program space table access datapath between the core and the flash.
  Assumes the flash answers a read strobe with data in the same cycle and
  that the core waits for done_out before issuing the next operation.
*/
module pstr_table_access
  import pstr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic req_in,
  input wire pstr_op_e op_in,
  input wire logic byte_mode_in,
  input wire logic [15:0] ea_in,
  input wire logic [15:0] wdata_in,
  input wire logic page_we_in,
  input wire logic [7:0] page_in,
  input wire logic [23:0] flash_rdata_in,
  output logic [7:0] page_out,
  output logic flash_rd_out,
  output logic flash_wr_out,
  output logic [23:0] flash_addr_out,
  output logic [23:0] flash_wdata_out,
  output logic [2:0] flash_wmask_out,
  output logic flash_cfg_out,
  output logic [15:0] rdata_out,
  output logic done_out
);
  typedef enum logic [1:0] {
    PSTR_IDLE,
    PSTR_WAIT
  } pstr_state_e;

  typedef struct packed {
    pstr_state_e state;
    logic [7:0] page;
    logic rd;
    logic wr;
    logic [23:0] addr;
    logic [23:0] wdata;
    logic [2:0] wmask;
    logic cfg;
    logic high;
    logic bmode;
    logic bsel;
    logic [15:0] rdata;
    logic done;
  } pstr_s;

  pstr_s cur;
  pstr_s next_cur;
  logic [15:0] lane_data;
  logic is_high;
  logic is_write;

  assign is_high = (op_in == PSTR_OP_RD_HIGH) || (op_in == PSTR_OP_WT_HIGH);
  assign is_write = (op_in == PSTR_OP_WT_LOW) || (op_in == PSTR_OP_WT_HIGH);

  // Steering of the returned word, from the operation captured at issue
  pstr_lane u_lane (
    .pword_in(flash_rdata_in),
    .high_in(cur.high),
    .byte_mode_in(cur.bmode),
    .byte_sel_in(cur.bsel),
    .data_out(lane_data)
  );

  // Next state of the whole block
  always_comb begin
    next_cur = cur;
    next_cur.rd = 1'b0;
    next_cur.wr = 1'b0;
    next_cur.done = 1'b0;
    // Page update is independent of the operation in flight
    if (page_we_in) begin
      next_cur.page = page_in;
    end
    case (cur.state)
      PSTR_IDLE: begin
        if (req_in) begin
          // Page selects the 64K window, EA is the byte address in it;
          // EA bit 0 is the byte select, so words sit at even addresses
          next_cur.addr = {cur.page, ea_in[15:1], 1'b0};
          next_cur.cfg = cur.page[PSTR_PAGE_CFG_BIT];
          next_cur.high = is_high;
          next_cur.bmode = byte_mode_in;
          next_cur.bsel = ea_in[0];
          if (is_write) begin
            // Low ops touch bits 15:0 only, high ops bits 23:16 only
            next_cur.wr = 1'b1;
            next_cur.done = 1'b1;
            if (!is_high) begin
              next_cur.wdata = {8'h00, byte_mode_in ?
                {wdata_in[7:0], wdata_in[7:0]} : wdata_in};
              next_cur.wmask = byte_mode_in ? (ea_in[0] ? 3'h2 : 3'h1) : 3'h3;
            end else begin
              // Writes to the phantom byte are dropped
              next_cur.wdata = {wdata_in[7:0], 16'h0000};
              next_cur.wmask = (byte_mode_in && ea_in[0]) ? 3'h0 : 3'h4;
            end
          end else begin
            next_cur.rd = 1'b1;
            next_cur.state = PSTR_WAIT;
          end
        end
      end
      PSTR_WAIT: begin
        next_cur.rdata = lane_data;
        next_cur.done = 1'b1;
        next_cur.state = PSTR_IDLE;
      end
      default: begin
        next_cur.state = PSTR_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur <= '{state: PSTR_IDLE, page: PSTR_PAGE_RST, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign page_out = cur.page;
  assign flash_rd_out = cur.rd;
  assign flash_wr_out = cur.wr;
  assign flash_addr_out = cur.addr;
  assign flash_wdata_out = cur.wdata;
  assign flash_wmask_out = cur.wmask;
  assign flash_cfg_out = cur.cfg;
  assign rdata_out = cur.rdata;
  assign done_out = cur.done;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  // A request taken while idle; every check below except refuse_wait_a and page_load_a starts from one of these
  sequence take_s;
    req_in && cur.state == PSTR_IDLE;
  endsequence

  sequence rd_issue_s;
    take_s ##0 !is_write;
  endsequence

  sequence wt_issue_s;
    take_s ##0 is_write;
  endsequence

  // Read answer: strobe first, then result and done, never overlapping
  sequence rd_answer_s;
    (flash_rd_out && !done_out) ##1 (done_out && !flash_rd_out);
  endsequence

  // Read steering, judged against the word the flash showed during the strobe
  word_low_read_a: assert property (
    rd_issue_s ##0 (op_in == PSTR_OP_RD_LOW && !byte_mode_in)
    |-> ##2 (done_out && rdata_out == $past(flash_rdata_in[15:0])))
    else $error("word low read data wrong");
  byte_low_read_a: assert property (
    rd_issue_s ##0 (op_in == PSTR_OP_RD_LOW && byte_mode_in)
    |-> ##2 (rdata_out[15:8] == 8'h00 && rdata_out[7:0] == ($past(ea_in[0], 2)
      ? $past(flash_rdata_in[15:8]) : $past(flash_rdata_in[7:0]))))
    else $error("byte low read data wrong");
  word_high_read_a: assert property (
    rd_issue_s ##0 (op_in == PSTR_OP_RD_HIGH && !byte_mode_in)
    |-> ##2 (rdata_out == {8'h00, $past(flash_rdata_in[23:16])}))
    else $error("word high read data wrong");
  phantom_zero_a: assert property (
    rd_issue_s ##0 (op_in == PSTR_OP_RD_HIGH && byte_mode_in && ea_in[0])
    |-> ##2 (rdata_out == 16'h0000))
    else $error("phantom byte not zero");
  high_byte_sel_a: assert property (
    rd_issue_s ##0 (op_in == PSTR_OP_RD_HIGH && byte_mode_in && !ea_in[0])
    |-> ##2 (rdata_out == {8'h00, $past(flash_rdata_in[23:16])}))
    else $error("high byte read data wrong");
  read_timing_a: assert property (
    rd_issue_s |=> rd_answer_s)
    else $error("read strobe or done out of step");
  // A request in the wait cycle is dropped, so nothing is launched after it
  refuse_wait_a: assert property (
    cur.state == PSTR_WAIT |=> (!flash_rd_out && !flash_wr_out))
    else $error("request taken during read wait");

  // Address and space follow the page held when the request was taken
  cfg_space_a: assert property (
    take_s |=> flash_cfg_out == $past(cur.page[PSTR_PAGE_CFG_BIT]))
    else $error("space select wrong");
  page_addr_a: assert property (
    take_s |=> flash_addr_out == {$past(cur.page), $past(ea_in[15:1]), 1'b0})
    else $error("program address wrong");
  page_load_a: assert property (
    page_we_in |=> page_out == $past(page_in))
    else $error("page register not loaded");

  // Write lanes: low ops never reach bits 23:16, high ops never bits 15:0
  high_write_mask_a: assert property (
    wt_issue_s ##0 (op_in == PSTR_OP_WT_HIGH)
    |=> (flash_wr_out && flash_wmask_out[1:0] == 2'h0))
    else $error("high write touched low word");
  low_write_mask_a: assert property (
    wt_issue_s ##0 (op_in == PSTR_OP_WT_LOW)
    |=> (flash_wr_out && !flash_wmask_out[2]))
    else $error("low write touched upper byte");
  low_byte_lane_a: assert property (
    wt_issue_s ##0 (op_in == PSTR_OP_WT_LOW && byte_mode_in)
    |=> (flash_wmask_out == ($past(ea_in[0]) ? 3'h2 : 3'h1)))
    else $error("byte write lane wrong");
  high_store_a: assert property (
    wt_issue_s ##0 (op_in == PSTR_OP_WT_HIGH)
    |=> (done_out && flash_wdata_out[23:16] == $past(wdata_in[7:0])))
    else $error("high write data wrong");
endmodule

/* testbench.sv */
/* Self-checking bench for the table access block.
   Assumes the flash model answers within the read strobe cycle. */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench
  import pstr_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic req_in = 1'b0;
  logic byte_mode_in = 1'b0;
  logic page_we_in = 1'b0;
  pstr_op_e op_in = PSTR_OP_RD_LOW;
  logic [15:0] ea_in = 16'h0000;
  logic [15:0] wdata_in = 16'h0000;
  logic [7:0] page_in = 8'h00;
  logic [7:0] pg = 8'h00;
  logic [7:0] page_out;
  logic [15:0] rdata_out;
  logic [23:0] flash_rdata_in, flash_addr_out, flash_wdata_out;
  logic [2:0] flash_wmask_out;
  logic flash_rd_out, flash_wr_out, flash_cfg_out, done_out;
  int error_cnt = 0;
  int total_checks = 0;
  // 200 MHz core clock
  always #2.5 clk_sys_in = ~clk_sys_in;
  pstr_table_access i_pstr_table_access (.clk_sys_in, .rstn_in, .req_in, .op_in,
    .byte_mode_in, .ea_in, .wdata_in, .page_we_in, .page_in, .flash_rdata_in,
    .page_out, .flash_rd_out, .flash_wr_out, .flash_addr_out, .flash_wdata_out,
    .flash_wmask_out, .flash_cfg_out, .rdata_out, .done_out);
  pstr_flash_model i_pstr_flash_model (.rd_in(flash_rd_out), .addr_in(flash_addr_out),
    .rdata_out(flash_rdata_in));
  // Bench copy of the flash contents, kept apart from the model
  function automatic logic [23:0] mem(logic [23:0] a);
    return {a[7:0] ^ 8'h5A, a[15:0] ^ 16'hC3A5};
  endfunction
  // One request cycle, launched and dropped on falling edges
  task automatic issue(pstr_op_e op, logic bm, logic [15:0] ea);
    @(negedge clk_sys_in);
    req_in = 1'b1;
    op_in = op;
    byte_mode_in = bm;
    ea_in = ea;
    @(negedge clk_sys_in);
    req_in = 1'b0;
  endtask
  task automatic rd(logic hi, logic bm, logic [15:0] ea);
    logic [23:0] w;
    logic [15:0] e;
    w = mem({pg, ea[15:1], 1'b0});
    e = hi ? {8'h00, w[23:16]} : w[15:0];
    if (bm) e = {8'h00, hi ? (ea[0] ? 8'h00 : w[23:16]) : (ea[0] ? w[15:8] : w[7:0])};
    issue(hi ? PSTR_OP_RD_HIGH : PSTR_OP_RD_LOW, bm, ea);
    `CHK(flash_rd_out, 1'b1)
    `CHK(flash_addr_out, {pg, ea[15:1], 1'b0})
    `CHK(flash_cfg_out, pg[7])
    @(negedge clk_sys_in);
    `CHK(done_out, 1'b1)
    `CHK(rdata_out, e)
  endtask
  task automatic wr(logic hi, logic bm, logic [15:0] ea, logic [2:0] m);
    wdata_in = 16'hA55A;
    issue(hi ? PSTR_OP_WT_HIGH : PSTR_OP_WT_LOW, bm, ea);
    `CHK(flash_wr_out & done_out, 1'b1)
    `CHK(flash_wmask_out, m)
    `CHK(flash_wdata_out, hi ? 24'h5A0000 : (bm ? 24'h005A5A : 24'h00A55A))
  endtask
  task automatic setpg(logic [7:0] p);
    @(negedge clk_sys_in);
    page_we_in = 1'b1;
    page_in = p;
    @(negedge clk_sys_in);
    page_we_in = 1'b0;
    pg = p;
    `CHK(page_out, p)
  endtask
  // Every read kind, word and byte, both byte selects
  task automatic t_reads();
    setpg(8'h12);
    for (int i = 0; i < 8; i++) begin
      rd(i[2], i[1], 16'h4F3A + 16'(i[0]));
    end
  endtask
  // Configuration page, then the last user page
  task automatic t_page();
    setpg(8'h80);
    rd(1'b0, 1'b0, 16'hFFFE);
    setpg(8'h7F);
    rd(1'b1, 1'b1, 16'h0001);
    rd(1'b0, 1'b1, 16'h4F3B + 16'(PSTR_ADDR_STEP));
  endtask
  // A request held high into the read wait cycle must be ignored
  task automatic t_refuse();
    logic [23:0] w;
    w = mem({pg, 16'h0200});
    @(negedge clk_sys_in);
    req_in = 1'b1;
    op_in = PSTR_OP_RD_LOW;
    byte_mode_in = 1'b0;
    ea_in = 16'h0200;
    @(negedge clk_sys_in);
    op_in = PSTR_OP_WT_LOW;
    @(negedge clk_sys_in);
    req_in = 1'b0;
    `CHK(flash_wr_out, 1'b0)
    `CHK(done_out, 1'b1)
    `CHK(rdata_out, w[15:0])
    @(negedge clk_sys_in);
    `CHK(done_out, 1'b0)
    `CHK(flash_wr_out, 1'b0)
  endtask
  // Mid-run reset clears the page and the read result, then reads resume
  task automatic t_reset();
    setpg(8'h33);
    @(negedge clk_sys_in);
    rstn_in = 1'b0;
    @(negedge clk_sys_in);
    `CHK(page_out, PSTR_PAGE_RST)
    `CHK(rdata_out, 16'h0000)
    rstn_in = 1'b1;
    pg = PSTR_PAGE_RST;
    rd(1'b1, 1'b0, 16'h1234);
  endtask
  // Writes of every size and lane, one idle cycle apart
  task automatic t_writes();
    wr(1'b0, 1'b0, 16'h0100, 3'h3);
    wr(1'b0, 1'b1, 16'h0100, 3'h1);
    wr(1'b0, 1'b1, 16'h0101, 3'h2);
    wr(1'b1, 1'b0, 16'h0100, 3'h4);
    wr(1'b1, 1'b1, 16'h0100, 3'h4);
    wr(1'b1, 1'b1, 16'h0101, 3'h0);
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk_sys_in);
    `CHK(page_out, PSTR_PAGE_RST)
    rstn_in = 1'b1;
    t_reads();
    t_page();
    t_writes();
    t_refuse();
    t_reset();
    final_report();
  end
  // Whole run is under 200 cycles; a hang ends here
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
endmodule
